/* common/bus_err_consts.vh */
// Purpose: constants for the processor-bus error log, mask and routing block
// Assumes: 16-bit registers reached by byte offset in configuration space
// Notes: definitions only
`ifndef BUS_ERR_CONSTS_VH
`define BUS_ERR_CONSTS_VH

// ==========================================================
// register offsets
`define OFS_FIRST_LOG 8'h60
`define OFS_NEXT_LOG 8'h62
`define OFS_MASK 8'h64
`define OFS_CTRL_EN 8'h68
`define OFS_MGMT_EN 8'h6a

// ==========================================================
// reset values and field layout
`define MASK_BOOT 16'h0009
`define ZERO16 16'h0000
`define ERR_BITS 10
`define ERR_MSB 9
`define IMPL_MASK 16'h03ff

`endif

/* verilog/bus_error_mask_routing.v */
// Purpose: processor-bus error logs, sticky mask and message routing
// Assumes: error sources are single-cycle or level events on clk_i
// Notes: logs and mask only restart on power-up init (pwr_init_i)
// Functional notes
// - next log mirrors first log, write-one clears
// - masked errors never logged nor messaged
// - mask survives ordinary reset, power-up restores
// - mask boots at 0009h, data parity masked
// - request parity mask bit zero boots set
// - mask bits map to ten error sources
// - mask zero enables, one suppresses
// - enabled logged flag sends control interrupt message
// - control enable bit n gates flag n
// - enabled logged flag sends management interrupt message
// - management enable bit n gates flag n, resets zero
// - first log holds the first error event, later go next
// - simultaneous first errors all latch in first log
// - logs sticky through reset, write-one clears
`timescale 1ns/1ps
`include "bus_err_consts.vh"

module bus_error_mask_routing #(
  parameter N = `ERR_BITS
) (
  // clock and resets
  input wire clk_i,
  input wire rst_i,
  input wire pwr_init_i,
  // error events from the bus unit
  input wire [N-1:0] err_event_i,
  // configuration register port
  input wire cfg_wr_i,
  input wire cfg_rd_i,
  input wire [7:0] cfg_addr_i,
  input wire [15:0] cfg_wdata_i,
  input wire [1:0] cfg_be_i,
  output reg [15:0] cfg_rdata_o,
  // hub link special cycle requests
  output reg ctrl_irq_msg_o,
  output reg mgmt_irq_msg_o
);

  // ==========================================================
  // state
  reg [N-1:0] first_q, first_d;
  reg [N-1:0] next_q, next_d;
  reg [N-1:0] mask_q;
  reg [N-1:0] ctrl_en_q;
  reg [N-1:0] mgmt_en_q;
  reg [N-1:0] ctrl_sent_q;
  reg [N-1:0] mgmt_sent_q;
  wire [N-1:0] live_err;
  wire [N-1:0] wdata;
  wire [N-1:0] flags;
  wire [N-1:0] ctrl_new;
  wire [N-1:0] mgmt_new;
  wire [15:0] mask_boot;

  // boot mask kept at full register width, then cut to the live bits
  assign mask_boot = `MASK_BOOT;

  // byte-lane write enable on one register; bits 15:10 do not exist
  function [N-1:0] wr_bits;
    input [7:0] ofs;
    reg [15:0] lanes;
    begin
      lanes = {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
      wr_bits = (cfg_wr_i && cfg_addr_i == ofs) ? lanes[N-1:0] : {N{1'b0}};
    end
  endfunction

  assign wdata = cfg_wdata_i[N-1:0];
  // masked sources are ignored entirely
  assign live_err = err_event_i & ~mask_q;

  // ==========================================================
  // log update: set wins over a write-one clear in the same cycle
  always @* begin
    first_d = first_q & ~(wdata & wr_bits(`OFS_FIRST_LOG));
    next_d = next_q & ~(wdata & wr_bits(`OFS_NEXT_LOG));
    if (first_q == {N{1'b0}}) begin
      first_d = first_d | live_err;
    end else begin
      next_d = next_d | live_err;
    end
  end

  // ==========================================================
  // sticky registers: ordinary reset leaves them alone
  always @(posedge clk_i) begin
    if (pwr_init_i) begin
      first_q <= {N{1'b0}};
      next_q <= {N{1'b0}};
      mask_q <= mask_boot[N-1:0];
    end else begin
      first_q <= first_d;
      next_q <= next_d;
      mask_q <= (mask_q & ~wr_bits(`OFS_MASK)) | (wdata & wr_bits(`OFS_MASK));
    end
  end

  // ==========================================================
  // routing enables, cleared on ordinary reset
  always @(posedge clk_i) begin
    if (rst_i || pwr_init_i) begin
      ctrl_en_q <= {N{1'b0}};
      mgmt_en_q <= {N{1'b0}};
    end else begin
      ctrl_en_q <= (ctrl_en_q & ~wr_bits(`OFS_CTRL_EN)) | (wdata & wr_bits(`OFS_CTRL_EN));
      mgmt_en_q <= (mgmt_en_q & ~wr_bits(`OFS_MGMT_EN)) | (wdata & wr_bits(`OFS_MGMT_EN));
    end
  end

  // ==========================================================
  // message generation; both types may fire if software breaks
  // the one-type-per-source convention, which is its burden
  assign flags = first_q | next_q;
  assign ctrl_new = flags & ctrl_en_q & ~ctrl_sent_q;
  assign mgmt_new = flags & mgmt_en_q & ~mgmt_sent_q;

  // sent marks rearm when the flag is cleared or on either reset
  always @(posedge clk_i) begin
    if (rst_i || pwr_init_i) begin
      ctrl_sent_q <= {N{1'b0}};
      mgmt_sent_q <= {N{1'b0}};
      ctrl_irq_msg_o <= 1'b0;
      mgmt_irq_msg_o <= 1'b0;
    end else begin
      ctrl_sent_q <= (ctrl_sent_q | ctrl_new) & flags;
      mgmt_sent_q <= (mgmt_sent_q | mgmt_new) & flags;
      ctrl_irq_msg_o <= |ctrl_new;
      mgmt_irq_msg_o <= |mgmt_new;
    end
  end

  // ==========================================================
  // read mux, one cycle latency; unmapped offsets read zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg_rdata_o <= `ZERO16;
    end else if (!cfg_rd_i) begin
      cfg_rdata_o <= cfg_rdata_o;
    end else if (cfg_addr_i == `OFS_FIRST_LOG) begin
      cfg_rdata_o <= {6'h00, first_q};
    end else if (cfg_addr_i == `OFS_NEXT_LOG) begin
      cfg_rdata_o <= {6'h00, next_q};
    end else if (cfg_addr_i == `OFS_MASK) begin
      cfg_rdata_o <= {6'h00, mask_q};
    end else if (cfg_addr_i == `OFS_CTRL_EN) begin
      cfg_rdata_o <= {6'h00, ctrl_en_q};
    end else if (cfg_addr_i == `OFS_MGMT_EN) begin
      cfg_rdata_o <= {6'h00, mgmt_en_q};
    end else begin
      cfg_rdata_o <= `ZERO16;
    end
  end

endmodule

/* test/bus_err_chk.sv */
// Purpose: port checks of the bus error block
// Assumes: one clock; both resets mute checks
// Notes: bound at the foot
`timescale 1ns/1ps
`include "bus_err_consts.vh"
module bus_err_chk #(parameter N = 10) (input wire clk_i, rst_i, pwr_init_i, cfg_wr_i, cfg_rd_i,
  ctrl_irq_msg_o, mgmt_irq_msg_o, input wire [N-1:0] err_event_i, input wire [7:0] cfg_addr_i,
  input wire [15:0] cfg_wdata_i, cfg_rdata_o, input wire [1:0] cfg_be_i);
  // ==========
  // properties, all on clk_i
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || pwr_init_i);
  rsvd_zero_a: assert property (cfg_rdata_o[15:10] == 0) else $error("reserved bits set");
  unmap_zero_a: assert property ($past(cfg_rd_i) && $past(cfg_addr_i) > 8'h6b |-> !cfg_rdata_o) else $error("unmap");
  quiet_rst_a: assert property ($past(rst_i) |-> !ctrl_irq_msg_o && !mgmt_irq_msg_o) else $error("msg in reset");
  ctrl_why_a: assert property (ctrl_irq_msg_o |-> $past(err_event_i, 2) || $past(cfg_wr_i, 2)) else $error("ctrl");
  mgmt_why_a: assert property (mgmt_irq_msg_o |-> $past(err_event_i, 2) || $past(cfg_wr_i, 2)) else $error("mgmt");
  mask_boot_a:
    assert property ($past(pwr_init_i, 3) && $past(cfg_rd_i) && $past(cfg_addr_i) == 8'h64 |-> cfg_rdata_o == 16'h0009)
      else $error("boot mask");
  en_rst_a:
    assert property ($past(rst_i, 3) && $past(cfg_rd_i) && $past(cfg_addr_i) == 8'h68 |-> !cfg_rdata_o) else $error("en");
  mask_rw_a:
    assert property ($past(cfg_wr_i, 3) && $past(cfg_rd_i) && $past(cfg_addr_i, 3) == 8'h64 && $past(cfg_addr_i) == 8'h64
      |-> cfg_rdata_o == ($past(cfg_wdata_i, 3) & `IMPL_MASK)) else $error("mask rw");
  cover property (ctrl_irq_msg_o);
  cover property (mgmt_irq_msg_o);
  cover property ($past(cfg_rd_i) && $past(cfg_addr_i) > 8'h6b);
endmodule
bind bus_error_mask_routing bus_err_chk #(.N(N)) chk_i (.*);

/* test/hub_link_sink.sv */
// Purpose: far end of the hub link
// Assumes: requests are one-cycle pulses
// Notes: always accepts, so it never stalls
`timescale 1ns/1ps
module hub_link_sink (input wire clk_i, ctrl_i, mgmt_i, output int ctrl_cnt_o = 0, output int mgmt_cnt_o = 0);
  // ==========
  // count each special cycle seen
  always @(posedge clk_i) begin
    if (ctrl_i === 1'b1) ctrl_cnt_o <= ctrl_cnt_o + 1;
    if (mgmt_i === 1'b1) mgmt_cnt_o <= mgmt_cnt_o + 1;
  end
endmodule

/* test/sysbus_error_mask_and_routing_tb_top.sv */
// Purpose: bench for the bus error block
// Assumes: power-up init held with reset
// Notes: message counts from the link model
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; $display("[ERR] %0t bad %h", $time, a); end end
module sysbus_error_mask_and_routing_tb_top;
  // ==========
  // bench signals; lanes both enabled except during the low-lane write to 6ah
  logic clk_i = 0, rst_i = 1, pwr_init_i = 1, cfg_wr_i = 0, cfg_rd_i = 0, ctrl_irq_msg_o, mgmt_irq_msg_o;
  logic [9:0] err_event_i = 0;
  logic [7:0] cfg_addr_i = 0;
  logic [15:0] cfg_wdata_i = 0, cfg_rdata_o;
  logic [1:0] cfg_be_i = 2'h3;
  int err_count = 0, n_compared = 0, cyc = 0, n_ctrl, n_mgmt;
  bus_error_mask_routing uut (.*);
  hub_link_sink far_i (.clk_i, .ctrl_i(ctrl_irq_msg_o), .mgmt_i(mgmt_irq_msg_o), .ctrl_cnt_o(n_ctrl), .mgmt_cnt_o(n_mgmt));
  // clock and hang guard
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (++cyc > 2000) begin err_count++; stop_test(); end
  // register write, read-compare, error pulse, reset pulse
  task w(input [7:0] a, input [15:0] d);
    @(posedge clk_i) {cfg_wr_i, cfg_addr_i, cfg_wdata_i} <= {1'b1, a, d};
    @(posedge clk_i) cfg_wr_i <= 0;
  endtask
  task r(input [7:0] a, input [15:0] x);
    @(posedge clk_i) {cfg_rd_i, cfg_addr_i} <= {1'b1, a};
    @(posedge clk_i) cfg_rd_i <= 0;
    @(posedge clk_i) #1 `CHK(cfg_rdata_o, x)
  endtask
  task e(input [9:0] b);
    @(posedge clk_i) err_event_i <= b;
    @(posedge clk_i) err_event_i <= 0;
    repeat (3) @(posedge clk_i);
  endtask
  task p;
    @(posedge clk_i) rst_i <= 1;
    @(posedge clk_i) rst_i <= 0;
  endtask
  task stop_test;
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // scenarios; enable routing kept to one type per source
  initial begin
    repeat (5) @(posedge clk_i);
    {rst_i, pwr_init_i} <= 2'b00;
    r(8'h64, 16'h0009);
    w(8'h64, 16'hffff); r(8'h64, 16'h03ff);
    p(); r(8'h64, 16'h03ff);
    e(10'h010); r(8'h60, 0);
    w(8'h64, 0); w(8'h68, 16'h0110); w(8'h6a, 16'h0020);
    e(10'h010); `CHK(n_ctrl, 1)
    e(10'h030); `CHK(n_mgmt, 1)
    `CHK(n_ctrl, 1)
    r(8'h60, 16'h0010); r(8'h62, 16'h0030);
    w(8'h60, 16'h0010); e(10'h0c0); r(8'h60, 16'h00c0);
    p(); r(8'h68, 0); r(8'h62, 16'h0030);
    w(8'h62, 16'h0010); r(8'h62, 16'h0020);
    w(8'h68, 16'h0100); w(8'h64, 16'h0100); e(10'h100); r(8'h62, 16'h0020);
    `CHK(n_ctrl, 1)
    // low lane only: upper byte of the write must be dropped
    cfg_be_i <= 2'h1;
    w(8'h6a, 16'h0301);
    cfg_be_i <= 2'h3;
    r(8'h6a, 16'h0001);
    // power-up init mid-run restores boot mask and empties logs
    @(posedge clk_i) pwr_init_i <= 1'b1;
    @(posedge clk_i) pwr_init_i <= 1'b0;
    r(8'h64, 16'h0009); r(8'h62, 0);
    r(8'h70, 0);
    stop_test();
  end
endmodule
